/* File: design/iis_ahb_slave.sv */
/*
  AHB-Lite slave front end: word transfers only, writes with no wait
  state, reads with one wait state so that read data comes from a
  flip-flop and already sees a write just before. Response is OKAY.
  Assumes the single master drives hready from hreadyout.
*/
`timescale 1ns/100ps
module iis_ahb_slave
  import iis_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             wr_en,
  output iis_wr_s          wr,
  output logic      [7:0]  rd_addr,
  input  wire logic [31:0] rd_data
);

`include "iis_regs.svh"

  logic       a_ok;
  logic       d_wr;
  logic [7:0] d_addr;
  iis_phase_e phase;
  iis_phase_e next_phase;

  // Other sizes are ignored rather than partially written
  assign a_ok = hsel & htrans[1] & hready & (hsize == `IIS_HSIZE_WORD);
  assign next_phase = (phase == IIS_PH_RWAIT) ? IIS_PH_IDLE :
                      (a_ok & ~hwrite)        ? IIS_PH_RWAIT : IIS_PH_IDLE;
  assign hreadyout = (phase != IIS_PH_RWAIT);
  assign hresp     = 1'b0;
  assign wr_en     = d_wr;
  assign wr.addr   = d_addr;
  assign wr.data   = hwdata;
  assign rd_addr   = d_addr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_wr   <= 1'b0;
      d_addr <= 8'h00;
    end else if (hready) begin
      d_wr   <= a_ok & hwrite;
      d_addr <= a_ok ? haddr[7:0] : d_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase  <= IIS_PH_IDLE;
      hrdata <= 32'h0000_0000;
    end else begin
      phase  <= next_phase;
      hrdata <= (phase == IIS_PH_RWAIT) ? rd_data : hrdata;
    end
  end

endmodule

/* File: design/iis_pkg.sv */
/*
  Types shared by the interrupt status block: bus write request,
  incoming event group, serial clock pin group and slave phase.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iis_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } iis_wr_s;

  typedef struct packed {
    logic tx_overrun;
    logic tgt_write;
    logic tgt_read;
    logic ctrl_done_nostop;
  } iis_evt_s;

  typedef struct packed {
    logic out;
    logic oen_n;
  } iis_scl_s;

  typedef enum logic [0:0] {
    IIS_PH_IDLE  = 1'b0,
    IIS_PH_RWAIT = 1'b1
  } iis_phase_e;

endpackage

/* File: design/iis_regs.svh */
/*
  Register map, field positions and reset values of the interrupt
  status block. Included by the slave and top design files and the checker and testbench files; holds definitions only.
*/
`ifndef IIS_REGS_SVH
`define IIS_REGS_SVH

`define IIS_OFF_CMD      8'h00
`define IIS_OFF_STATUS   8'h04
`define IIS_OFF_LIMIT    8'h10
`define IIS_OFF_MASK     8'h2c
`define IIS_OFF_RAW      8'h30
`define IIS_OFF_MASKED   8'h34
`define IIS_OFF_CLEAR    8'h38

`define IIS_BIT_TXE      0
`define IIS_BIT_TXLOW    1
`define IIS_BIT_TXFULL   2
`define IIS_BIT_TXOVR    3
`define IIS_BIT_TGTRD    16
`define IIS_BIT_TGTWR    18
`define IIS_BIT_DWS      28

`define IIS_STAT_DONE    0
`define IIS_STAT_WDEFER  1
`define IIS_STAT_RDEFER  2
`define IIS_STAT_REFUSED 3
`define IIS_STAT_SCL     4

`define IIS_IMPL_MASK    32'h1005_000f
`define IIS_RST_WORD     32'h0000_0000
`define IIS_HSIZE_WORD   3'h2

`endif

/* File: design/iis_sticky.sv */
/*
  Vector of sticky event flags with write-one-to-clear.
  Assumes set and clear pulses are synchronous to hclk.
*/
`timescale 1ns/100ps
module iis_sticky #(
  parameter int W = 4
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  logic [W-1:0] next_q;

  // Set wins so an event in the clearing cycle is kept
  assign next_q = (q & ~clr) | set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

/* File: design/iis_top.sv */
/*
  Interrupt status block of a two-wire controller/target: raw and
  masked flag registers, clear and mask registers, controller command
  gating, target request deferral and clock stretching.
  Assumes the transmit FIFO, the bus engine and the pin pad are outside;
  their events arrive as one-cycle pulses on hclk.
*/
`timescale 1ns/100ps

// Function
// - Command writes are refused while the done-without-stop flag is set.
// - Target write and read requests are held back until the flag clears.
// - Serial clock line is held low while the flag is pending.
// - Flag sits at raw bit 28, resets to 0, cleared by clear bit 28.
// - Flag reads 1 when transaction awaits acknowledgment, 0 after it.
// - Bits 31 to 29 of raw and masked status always read zero.
// - Masked status register at offset 0x34, read-only, resets to zero.
// - Masked bit 0 shows transmit FIFO empty.
// - Masked bit 1 shows fill level at or below the programmed limit.
// - Masked bit 2 shows transmit FIFO full.
// - Masked bit 3 shows a transmit FIFO overrun has happened.
// - Writing one to clear bit 3 drops the overrun; zero does nothing.
module iis_top
  import iis_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int CNT_W    = 5
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire logic [CNT_W-1:0] tx_count,
  input  wire iis_evt_s         evt,
  input  wire logic             scl_in,
  output iis_scl_s              scl,
  output logic                  cmd_start,
  output logic      [31:0]      cmd_word,
  output logic                  irq
);

`include "iis_regs.svh"

  // Address decode shared by writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Places the four sticky flags and three levels into the word layout
  function automatic logic [31:0] layout(input logic [3:0] st,
                                         input logic       txe,
                                         input logic       txlow,
                                         input logic       txfull);
    logic [31:0] w;
    w = `IIS_RST_WORD;
    w[`IIS_BIT_TXE]    = txe;
    w[`IIS_BIT_TXLOW]  = txlow;
    w[`IIS_BIT_TXFULL] = txfull;
    w[`IIS_BIT_TXOVR]  = st[0];
    w[`IIS_BIT_TGTRD]  = st[1];
    w[`IIS_BIT_TGTWR]  = st[2];
    w[`IIS_BIT_DWS]    = st[3];
    layout = w;
  endfunction

  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(TX_DEPTH);

  // Bus side
  logic             wr_en;
  iis_wr_s          wr;
  logic [7:0]       rd_addr;
  logic [31:0]      rd_data;

  // Software registers
  logic [31:0]      mask;
  logic [CNT_W-1:0] limit;
  logic             refused;

  // Sticky flags: 0 overrun, 1 read request, 2 write request, 3 done
  logic [3:0]       sticky_set;
  logic [3:0]       sticky_clr;
  logic [3:0]       sticky;

  // Target requests seen while the done flag was pending
  logic             wdefer;
  logic             rdefer;
  logic             next_wdefer;
  logic             next_rdefer;

  // Decoded strobes
  logic             wr_cmd;
  logic             wr_limit;
  logic             wr_mask;
  logic             wr_clear;
  logic             cmd_ok;
  logic             dws;

  // Status words
  logic             txe;
  logic             txlow;
  logic             txfull;
  logic [31:0]      raw_word;
  logic [31:0]      masked_word;
  logic [31:0]      status_word;

  iis_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr        (wr),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  assign wr_cmd   = wr_en & hit(wr.addr, `IIS_OFF_CMD);
  assign wr_limit = wr_en & hit(wr.addr, `IIS_OFF_LIMIT);
  assign wr_mask  = wr_en & hit(wr.addr, `IIS_OFF_MASK);
  assign wr_clear = wr_en & hit(wr.addr, `IIS_OFF_CLEAR);

  assign dws = sticky[3];

  // A new operation waits for the acknowledgment
  assign cmd_ok = wr_cmd & ~dws;

  // Clearing is by writing ones only; zeros leave flags alone
  assign sticky_clr[0] = wr_clear & wr.data[`IIS_BIT_TXOVR];
  assign sticky_clr[1] = wr_clear & wr.data[`IIS_BIT_TGTRD];
  assign sticky_clr[2] = wr_clear & wr.data[`IIS_BIT_TGTWR];
  assign sticky_clr[3] = wr_clear & wr.data[`IIS_BIT_DWS];

  // Requests pass straight through unless the done flag holds them
  assign sticky_set[0] = evt.tx_overrun;
  assign sticky_set[1] = (evt.tgt_read | rdefer) & ~dws;
  assign sticky_set[2] = (evt.tgt_write | wdefer) & ~dws;
  assign sticky_set[3] = evt.ctrl_done_nostop;

  assign next_rdefer = (rdefer | evt.tgt_read) & dws;
  assign next_wdefer = (wdefer | evt.tgt_write) & dws;

  iis_sticky #(
    .W (4)
  ) u_sticky (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (sticky_set),
    .clr     (sticky_clr),
    .q       (sticky)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdefer <= 1'b0;
      rdefer <= 1'b0;
    end else begin
      wdefer <= next_wdefer;
      rdefer <= next_rdefer;
    end
  end

  // Level conditions follow the FIFO fill count directly
  assign txe    = (tx_count == '0);
  assign txlow  = (tx_count <= limit);
  assign txfull = (tx_count >= FULL_CNT);

  // Reserved top bits stay zero through the layout function
  assign raw_word    = layout(sticky, txe, txlow, txfull);
  assign masked_word = raw_word & mask;

  assign status_word = {27'h0000000,
                        scl_in,
                        refused,
                        rdefer,
                        wdefer,
                        dws};

  // Unmapped and write-only offsets read zero
  assign rd_data =
    hit(rd_addr, `IIS_OFF_CMD)    ? cmd_word                    :
    hit(rd_addr, `IIS_OFF_STATUS) ? status_word                 :
    hit(rd_addr, `IIS_OFF_LIMIT)  ? {{(32-CNT_W){1'b0}}, limit} :
    hit(rd_addr, `IIS_OFF_MASK)   ? mask                        :
    hit(rd_addr, `IIS_OFF_RAW)    ? raw_word                    :
    hit(rd_addr, `IIS_OFF_MASKED) ? masked_word                 :
                                    `IIS_RST_WORD;

  // Mask holds only implemented bit positions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask  <= `IIS_RST_WORD;
      limit <= '0;
    end else begin
      mask  <= wr_mask ? (wr.data & `IIS_IMPL_MASK) : mask;
      limit <= wr_limit ? wr.data[CNT_W-1:0] : limit;
    end
  end

  // Refused commands leave the previous word in place
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_word  <= `IIS_RST_WORD;
      cmd_start <= 1'b0;
      refused   <= 1'b0;
    end else begin
      cmd_word  <= cmd_ok ? wr.data : cmd_word;
      cmd_start <= cmd_ok;
      refused   <= wr_cmd ? dws : refused;
    end
  end

  // Open drain: only a low level is ever driven
  assign scl.out   = 1'b0;
  assign scl.oen_n = ~dws;

  assign irq = |masked_word;

endmodule

/* File: tb/iis_bus_agent.sv */
/* Far side of the block: FIFO level, bus engine events and the
   pulled-up serial clock line. Driven by the bench through tasks. */
`timescale 1ns/100ps
module iis_bus_agent
  import iis_pkg::*;
#(
  parameter int CNT_W = 5
) (
  input  wire logic             hclk,
  input  wire iis_scl_s         scl,
  output logic      [CNT_W-1:0] tx_count,
  output iis_evt_s              evt,
  output logic                  scl_in
);
  // Pull-up: a released line reads high, never the last driven level
  assign scl_in = scl.oen_n ? 1'b1 : scl.out;
  initial begin
    tx_count = '0;
    evt = '0;
  end
  task automatic pulse(input iis_evt_s e);
    evt <= e;
    @(posedge hclk);
    evt <= '0;
  endtask
  task automatic level(input logic [CNT_W-1:0] n);
    tx_count <= n;
  endtask
endmodule

/* File: tb/iis_top_chk.sv */
/* Port-level assertions for iis_top.
   Assumes hready is wired to hreadyout and a single master. */
`timescale 1ns/100ps
`include "iis_regs.svh"
module iis_top_chk
  import iis_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int CNT_W    = 5
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic [CNT_W-1:0] tx_count,
  input wire iis_evt_s         evt,
  input wire logic             scl_in,
  input wire iis_scl_s         scl,
  input wire logic             cmd_start,
  input wire logic [31:0]      cmd_word,
  input wire logic             irq
);
  logic acc;
  logic wa_q;
  logic wc_q;
  // Data phase of a clear or command write follows these flags
  assign acc = hsel && htrans[1] && hready && hsize == `IIS_HSIZE_WORD;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {wa_q, wc_q} <= 2'h0;
    else {wa_q, wc_q} <= {2{acc && hwrite}} &
      {haddr[7:0] == `IIS_OFF_CLEAR, haddr[7:0] == `IIS_OFF_CMD};

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  okay_resp_a: assert property (!hresp)
    else $error("response not OKAY");
  read_wait_a: assert property (
    acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  stretch_set_a: assert property (
    evt.ctrl_done_nostop |-> ##[1:2] !scl.oen_n && !scl.out)
    else $error("clock line not stretched");
  stretch_hold_a: assert property (!scl.oen_n && !wa_q |=> !scl.oen_n)
    else $error("clock line released early");
  release_cause_a: assert property ($rose(scl.oen_n) |-> $past(wa_q))
    else $error("flag cleared without a clear write");
  cmd_take_a: assert property (wc_q && scl.oen_n |=> cmd_start)
    else $error("command not started");
  cmd_refuse_a: assert property (
    wc_q && !scl.oen_n |=> !cmd_start && $stable(cmd_word))
    else $error("command taken while flag pending");
  cmd_word_a: assert property ($changed(cmd_word) |-> cmd_start)
    else $error("command word changed without start");

  cover property (cmd_start);
  cover property ($rose(scl.oen_n));
  cover property ($rose(irq));
endmodule

/* File: tb/iis_top_tb.sv */
/* Self-checking bench for iis_top with the bus agent on the far side.
   Assumes a single AHB-Lite master with hready tied to hreadyout. */
`timescale 1ns/100ps
`include "iis_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module iis_top_tb
  import iis_pkg::*;
();
  localparam int CNT_W = 5;
  localparam int TX_DEPTH = 16;
  typedef struct packed {
    logic [4:0] cnt;
    logic [4:0] lim;
    logic [2:0] lvl;
  } iis_row_s;
  logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic             scl_in, cmd_start, irq;
  logic [31:0]      haddr, hwdata, hrdata, cmd_word, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [CNT_W-1:0] tx_count;
  iis_evt_s         evt;
  iis_scl_s         scl;
  int               n_mismatch, compares, cyc;
  iis_row_s         rows [6] = '{'{5'h00, 5'h00, 3'h3},
    '{5'h01, 5'h00, 3'h0}, '{5'h01, 5'h01, 3'h2}, '{5'h0f, 5'h0e, 3'h0},
    '{5'h10, 5'h0f, 3'h4}, '{5'h10, 5'h10, 3'h6}};
  assign hready = hreadyout;
  iis_top #(.TX_DEPTH(TX_DEPTH), .CNT_W(CNT_W)) iis_top_i (.*);
  iis_bus_agent #(.CNT_W(CNT_W)) iis_bus_agent_i (.*);

  // Ready and data sampled at the negedge, stable through the next edge
  task automatic wait_rdy();
    logic rdy;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic cmd(input [31:0] d, input logic s, input [31:0] w);
    xfer(1'b1, `IIS_OFF_CMD, d);
    @(negedge hclk);
    `CHK(cmd_start, s)
    `CHK(cmd_word, w)
    @(posedge hclk);
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Run takes about 100 cycles; ceiling leaves wide margin
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `IIS_HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, `IIS_OFF_MASKED, 32'hffff_ffff);
    xfer(1'b0, `IIS_OFF_MASKED, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    xfer(1'b0, 8'h3c, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b1, `IIS_OFF_MASK, 32'hffff_ffff);
    foreach (rows[i]) begin
      iis_bus_agent_i.level(rows[i].cnt);
      xfer(1'b1, `IIS_OFF_LIMIT, {27'h0, rows[i].lim});
      xfer(1'b0, `IIS_OFF_MASKED, 32'h0);
      `CHK(rd, {29'h0, rows[i].lvl})
      `CHK(irq, |rows[i].lvl)
    end
    // Level bits masked off so the rest reads the same at any count
    xfer(1'b1, `IIS_OFF_MASK, `IIS_IMPL_MASK & 32'hffff_fff8);
    iis_bus_agent_i.pulse(4'h8);
    xfer(1'b1, `IIS_OFF_CLEAR, 32'h0);
    xfer(1'b0, `IIS_OFF_MASKED, 32'h0);
    `CHK(rd, 32'h8)
    xfer(1'b1, `IIS_OFF_CLEAR, 32'h8);
    xfer(1'b0, `IIS_OFF_MASKED, 32'h0);
    `CHK(rd, 32'h0)
    cmd(32'h1, 1'b1, 32'h1);
    iis_bus_agent_i.pulse(4'h1);
    xfer(1'b0, `IIS_OFF_MASKED, 32'h0);
    `CHK(rd, 32'h1000_0000)
    `CHK(irq, 1'b1)
    cmd(32'h5a, 1'b0, 32'h1);
    iis_bus_agent_i.pulse(4'h6);
    xfer(1'b0, `IIS_OFF_STATUS, 32'h0);
    `CHK(rd, 32'hf)
    xfer(1'b1, `IIS_OFF_CLEAR, 32'he000_0000);
    xfer(1'b0, `IIS_OFF_RAW, 32'h0);
    `CHK(rd, 32'h1000_0006)
    xfer(1'b1, `IIS_OFF_CLEAR, 32'h1000_0000);
    xfer(1'b0, `IIS_OFF_MASKED, 32'h0);
    `CHK(rd, 32'h0005_0000)
    `CHK(scl_in, 1'b1)
    cmd(32'ha5, 1'b1, 32'ha5);
    // Reset in mid-run with the done flag pending and state to lose
    iis_bus_agent_i.pulse(4'h1);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK({hreadyout, hresp, cmd_start, irq, scl}, 6'h21)
    `CHK(cmd_word, 32'h0)
    `CHK(hrdata, 32'h0)
    @(posedge hclk);
    // Byte-sized write must be dropped, so the mask stays clear
    hsize <= 3'h0;
    xfer(1'b1, `IIS_OFF_MASK, 32'hffff_ffff);
    hsize <= `IIS_HSIZE_WORD;
    xfer(1'b0, `IIS_OFF_RAW, 32'h0);
    `CHK(rd, 32'h0000_0004)
    `CHK(irq, 1'b0)
    tally_and_finish();
  end
endmodule

bind iis_top iis_top_chk #(.TX_DEPTH(TX_DEPTH), .CNT_W(CNT_W))
  iis_top_chk_i (.*);
